//--- src/tsm_pkg.sv
/*
  Constants for the touch-screen measurement control block: register indices, field positions, reset values, encodings and FSM states.
  Assumes a 32-bit AXI4-Lite register bus where the byte address is four times the register index.
*/
package tsm_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = ADDR_W - 2;

  // Register indices (byte address = 4 * index)
  localparam logic [IDX_W-1:0] IDX_SEQ_CFG = 10'h069;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h06a;
  localparam logic [IDX_W-1:0] IDX_X_HIGH = 10'h06b;
  localparam logic [IDX_W-1:0] IDX_Y_HIGH = 10'h06c;
  localparam logic [IDX_W-1:0] IDX_LOW_BITS = 10'h06d;
  localparam logic [IDX_W-1:0] IDX_Z_HIGH = 10'h06e;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h070;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h071;

  // touch_manual_control fields
  localparam int unsigned CTRL_SW_LSB = 0;
  localparam int unsigned CTRL_ROUTE_LSB = 4;
  localparam int unsigned CTRL_START_BIT = 6;
  localparam int unsigned CTRL_REF_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Sequence configuration fields
  localparam int unsigned CFG_AUTO_BIT = 0;
  localparam int unsigned CFG_DETECT_BIT = 1;
  localparam int unsigned CFG_TYPE_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // touch_result_low_bits fields
  localparam int unsigned LOW_X_LSB = 0;
  localparam int unsigned LOW_Y_LSB = 2;
  localparam int unsigned LOW_Z_LSB = 4;
  localparam int unsigned LOW_TOUCH_BIT = 6;

  // Interrupt status / mask bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_MEAS_BIT = 0;
  localparam int unsigned IRQ_SEQ_BIT = 1;
  localparam int unsigned IRQ_TOUCH_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // Electrode routing encodings
  localparam logic [1:0] ROUTE_XPOS = 2'h0;
  localparam logic [1:0] ROUTE_YPOS = 2'h1;
  localparam logic [1:0] ROUTE_XNEG = 2'h2;
  localparam logic [1:0] ROUTE_YNEG = 2'h3;

  // Switch patterns used by automatic sequences (bit order X+, X-, Y+, Y-)
  localparam logic [3:0] SW_OPEN = 4'h0;
  localparam logic [3:0] SW_DRIVE_X = 4'h3;
  localparam logic [3:0] SW_DRIVE_Y = 4'hc;
  localparam logic [3:0] SW_DRIVE_Z = 4'h6;

  // Sequence lengths
  localparam logic [2:0] SEQ_LEN_XYZ = 3'h5;
  localparam logic [2:0] SEQ_LEN_X = 3'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MEAS_X = 2'h0,
    MEAS_Y = 2'h1,
    MEAS_Z = 2'h2
  } tsm_meas_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_TOUCH = 2'h3
  } tsm_state_e;
endpackage

//--- src/tsm_touch_ctrl.sv
/*
  Touch-screen manual control and result read-back with an AXI4-Lite register slave,
  automatic sequencing, coherent X/Y snapshot and a masked interrupt.
  Assumes an external converter that takes a one-cycle start pulse and answers with a done pulse
  carrying a 10-bit result, and a pen-down level synchronous to core_clk_in.
*/
// The AXI4-Lite interface to the registers was decided locally.
// Overview of operation
// R1: Control bits 0..3 close the X+, X-, Y+, Y- drive switches when 1 and open them when 0.
// R2: Field 5:4 routes X+ (00), Y+ (01), X- (10) or Y- (11) to the converter input.
// R3: Results taken with an X electrode routed go to the X result, with a Y electrode to the Y result; sequences route Y+ for X and X+ for Y.
// R4: Setting start bit 6 with automatic sequencing off runs one measurement with the current switches and route.
// R5: Setting start bit 6 with automatic sequencing on ignores switches and route and runs one sequence of the chosen type.
// R6: The start bit clears itself when the measurement or sequence completes.
// R7: Bit 7 selects the converter reference: 0 the reference pin against ground, 1 the driven electrode pair.
// R8: The 10-bit X result reads as 8 upper bits in its own register and 2 low bits at 1:0 of the low-bits register.
// R9: The 10-bit Y result reads as 8 upper bits in its own register and 2 low bits at 3:2 of the low-bits register.
// R10: The 10-bit Z result reads as 8 upper bits in its own register and 2 low bits at 5:4 of the low-bits register.
// R11: Reading the X upper register snapshots X and Y so later reads return a consistent pair.
// R12: The result registers sit at consecutive addresses for one incrementing burst read.
// R13: Bit 6 of the low-bits register reads 1 while a touch is detected.
// R14: The automatic enable lets sequences be started by touch detection or the start bit; 0 disables them.
// R15: Sequence type 0 measures X, Y, Z, X, Y and type 1 measures X only, each followed by a touch check.
// R16: With touch detection enabled sequences repeat while touch stays set, otherwise one sequence runs.
// R17: A start write while an operation is in progress is ignored.
`timescale 1ns/1ps
module tsm_touch_ctrl
  import tsm_pkg::*;
#(
  parameter int unsigned RES_W = 10
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Converter and panel
  output logic conv_start_out,
  input wire logic conv_done_in,
  input wire logic [RES_W-1:0] conv_data_in,
  input wire logic touch_detect_in,
  output logic [3:0] screen_switch_bits_out,
  output logic [1:0] electrode_route_sel_out,
  output logic converter_ref_sel_out,
  // Interrupt
  output logic irq_out
);

  if (RES_W != 10) begin : g_bad_width
    $error("RES_W must be 10: the register split is 8 upper and 2 lower bits");
  end

  typedef struct packed {
    tsm_state_e st;
    logic [2:0] step;
    tsm_meas_e kind;
    logic auto_run;
    logic [7:0] ctrl;
    logic [2:0] cfg;
    logic [RES_W-1:0] x;
    logic [RES_W-1:0] y;
    logic [RES_W-1:0] z;
    logic [RES_W-1:0] snap_x;
    logic [RES_W-1:0] snap_y;
    logic touch;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [3:0] sw;
    logic [1:0] route;
    logic ref_sel;
    logic conv_start;
    logic aw_held;
    logic [IDX_W-1:0] waddr;
    logic w_held;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
  } tsm_state_s;

  tsm_state_s s;
  tsm_state_s next_s;

  logic wr_do;
  logic wr_ctrl;
  logic start_try;
  logic rd_take;
  logic [IDX_W-1:0] rd_idx;

  assign wr_do = s.aw_held && s.w_held && !s.bvalid;
  assign wr_ctrl = wr_do && s.wlane0 && (s.waddr == IDX_CTRL);
  assign start_try = wr_ctrl && s.wdata[CTRL_START_BIT];
  assign rd_take = s_axi_arvalid_in && s.arrdy;
  assign rd_idx = s_axi_araddr_in[ADDR_W-1:2];

  function automatic tsm_meas_e step_kind(input logic [2:0] step, input logic x_only);
    tsm_meas_e k;
    k = MEAS_X;
    if (!x_only) begin
      unique case (step)
        3'h1, 3'h4: k = MEAS_Y;
        3'h2: k = MEAS_Z;
        default: k = MEAS_X;
      endcase
    end
    return k;
  endfunction

  always_comb begin
    logic [IRQ_W-1:0] irq_set;
    logic [2:0] seq_len;
    irq_set = '0;
    seq_len = s.cfg[CFG_TYPE_BIT] ? SEQ_LEN_X : SEQ_LEN_XYZ; // see R15
    next_s = s;
    next_s.conv_start = 1'b0;

    next_s.touch = touch_detect_in;
    if (touch_detect_in && !s.touch) begin
      irq_set[IRQ_TOUCH_BIT] = 1'b1;
    end

    // Write channel: address and data are accepted independently
    if (s_axi_awvalid_in && s.awrdy) begin
      next_s.aw_held = 1'b1;
      next_s.waddr = s_axi_awaddr_in[ADDR_W-1:2];
    end
    if (s_axi_wvalid_in && s.wrdy) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata_in[7:0];
      next_s.wlane0 = s_axi_wstrb_in[0];
    end
    if (s.bvalid && s_axi_bready_in) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_do) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.waddr)
        IDX_CTRL: begin
          if (s.wlane0) begin
            next_s.ctrl[5:0] = s.wdata[5:0];
            next_s.ctrl[CTRL_REF_BIT] = s.wdata[CTRL_REF_BIT];
          end
        end
        IDX_SEQ_CFG: begin
          if (s.wlane0) begin
            next_s.cfg = s.wdata[2:0];
          end
        end
        IDX_IRQ_STATUS: begin
          if (s.wlane0) begin
            next_s.irq_st = s.irq_st & ~s.wdata[IRQ_W-1:0];
          end
        end
        IDX_IRQ_MASK: begin
          if (s.wlane0) begin
            next_s.irq_mask = s.wdata[IRQ_W-1:0];
          end
        end
        IDX_X_HIGH, IDX_Y_HIGH, IDX_LOW_BITS, IDX_Z_HIGH: begin
          next_s.bresp = RESP_OKAY;
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end

    // Read channel; results sit at consecutive indices for a burst of single reads
    if (s.rvalid && s_axi_rready_in) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 8'h00;
      unique case (rd_idx) // see R12
        IDX_CTRL: next_s.rdata = s.ctrl;
        IDX_SEQ_CFG: next_s.rdata = {5'h00, s.cfg};
        IDX_X_HIGH: begin
          next_s.rdata = s.x[RES_W-1:2]; // see R8
          next_s.snap_x = s.x; // see R11
          next_s.snap_y = s.y;
        end
        IDX_Y_HIGH: next_s.rdata = s.snap_y[RES_W-1:2]; // see R9
        IDX_Z_HIGH: next_s.rdata = s.z[RES_W-1:2]; // see R10
        IDX_LOW_BITS: begin
          next_s.rdata[LOW_X_LSB+:2] = s.snap_x[1:0]; // see R8
          next_s.rdata[LOW_Y_LSB+:2] = s.snap_y[1:0]; // see R9
          next_s.rdata[LOW_Z_LSB+:2] = s.z[1:0]; // see R10
          next_s.rdata[LOW_TOUCH_BIT] = s.touch; // see R13
        end
        IDX_IRQ_STATUS: next_s.rdata = {5'h00, s.irq_st};
        IDX_IRQ_MASK: next_s.rdata = {5'h00, s.irq_mask};
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end

    // Measurement sequencer
    unique case (s.st)
      ST_IDLE: begin
        if (start_try) begin
          next_s.ctrl[CTRL_START_BIT] = 1'b1;
          next_s.st = ST_CONV;
          next_s.conv_start = 1'b1;
          next_s.step = 3'h0;
          if (s.cfg[CFG_AUTO_BIT]) begin
            next_s.auto_run = 1'b1; // see R5
            next_s.kind = step_kind(3'h0, s.cfg[CFG_TYPE_BIT]);
          end else begin
            next_s.auto_run = 1'b0; // see R4
            next_s.kind = s.wdata[CTRL_ROUTE_LSB] ? MEAS_Y : MEAS_X; // see R3
          end
        end else if (s.cfg[CFG_AUTO_BIT] && s.cfg[CFG_DETECT_BIT] && s.touch) begin
          next_s.st = ST_CONV; // see R14
          next_s.conv_start = 1'b1;
          next_s.step = 3'h0;
          next_s.auto_run = 1'b1;
          next_s.kind = step_kind(3'h0, s.cfg[CFG_TYPE_BIT]);
        end
      end
      ST_CONV: begin
        // Start writes while busy are dropped: bit 6 is only set from idle
        if (conv_done_in) begin // see R17
          irq_set[IRQ_MEAS_BIT] = 1'b1;
          unique case (s.kind)
            MEAS_Y: next_s.y = conv_data_in; // see R3
            MEAS_Z: next_s.z = conv_data_in;
            default: next_s.x = conv_data_in;
          endcase
          if (s.auto_run) begin
            next_s.st = ST_TOUCH; // see R15
          end else begin
            next_s.st = ST_IDLE;
            next_s.ctrl[CTRL_START_BIT] = 1'b0; // see R6
          end
        end
      end
      ST_TOUCH: begin
        if (s.step + 3'h1 < seq_len) begin
          next_s.step = s.step + 3'h1;
          next_s.kind = step_kind(next_s.step, s.cfg[CFG_TYPE_BIT]);
          next_s.st = ST_CONV;
          next_s.conv_start = 1'b1;
        end else begin
          irq_set[IRQ_SEQ_BIT] = 1'b1;
          next_s.ctrl[CTRL_START_BIT] = 1'b0; // see R6
          if (s.cfg[CFG_DETECT_BIT] && s.cfg[CFG_AUTO_BIT] && touch_detect_in) begin
            next_s.step = 3'h0; // see R16
            next_s.kind = step_kind(3'h0, s.cfg[CFG_TYPE_BIT]);
            next_s.st = ST_CONV;
            next_s.conv_start = 1'b1;
          end else begin
            next_s.st = ST_IDLE;
            next_s.auto_run = 1'b0;
          end
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Manual operation drives the panel straight from the control bits
    if (!next_s.auto_run) begin
      next_s.sw = next_s.ctrl[CTRL_SW_LSB+:4]; // see R1
      next_s.route = next_s.ctrl[CTRL_ROUTE_LSB+:2]; // see R2
    end else if (next_s.st == ST_CONV) begin
      unique case (next_s.kind)
        MEAS_Y: begin
          next_s.sw = SW_DRIVE_Y;
          next_s.route = ROUTE_XPOS;
        end
        MEAS_Z: begin
          next_s.sw = SW_DRIVE_Z;
          next_s.route = ROUTE_XPOS;
        end
        default: begin
          next_s.sw = SW_DRIVE_X;
          next_s.route = ROUTE_YPOS;
        end
      endcase
    end else begin
      // Switches open between measurements so no panel current flows
      next_s.sw = SW_OPEN;
    end
    next_s.ref_sel = next_s.ctrl[CTRL_REF_BIT]; // see R7

    // Hardware set wins over a same-cycle write-one clear
    next_s.irq_st = next_s.irq_st | irq_set;
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);

    next_s.awrdy = !next_s.aw_held && !next_s.bvalid;
    next_s.wrdy = !next_s.w_held && !next_s.bvalid;
    next_s.arrdy = !next_s.rvalid;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.kind <= MEAS_X;
      s.ctrl <= CTRL_RESET;
      s.cfg <= CFG_RESET;
      s.irq_mask <= IRQ_MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready_out = s.awrdy;
  assign s_axi_wready_out = s.wrdy;
  assign s_axi_bvalid_out = s.bvalid;
  assign s_axi_bresp_out = s.bresp;
  assign s_axi_arready_out = s.arrdy;
  assign s_axi_rvalid_out = s.rvalid;
  assign s_axi_rdata_out = {24'h000000, s.rdata};
  assign s_axi_rresp_out = s.rresp;
  assign conv_start_out = s.conv_start;
  assign screen_switch_bits_out = s.sw;
  assign electrode_route_sel_out = s.route;
  assign converter_ref_sel_out = s.ref_sel;
  assign irq_out = s.irq;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_switch_follow_ctrl: assert property (!s.auto_run |-> screen_switch_bits_out == s.ctrl[3:0]) // see R1
    else $error("switch outputs differ from control bits in manual operation");
  a_route_follow_ctrl: assert property (!s.auto_run |-> electrode_route_sel_out == s.ctrl[5:4]) // see R2
    else $error("route output differs from routing field in manual operation");
  a_x_result_store: assert property ((s.st == ST_CONV && conv_done_in && s.kind == MEAS_X)
    |=> s.x == $past(conv_data_in)) // see R3
    else $error("X result not stored");
  a_manual_single_go: assert property ((s.st == ST_IDLE && start_try && !s.cfg[CFG_AUTO_BIT])
    |=> conv_start_out && !s.auto_run && electrode_route_sel_out == $past(s.wdata[5:4])) // see R4
    else $error("manual start did not launch one measurement");
  a_auto_seq_go: assert property ((s.st == ST_IDLE && start_try && s.cfg[CFG_AUTO_BIT])
    |=> conv_start_out && s.auto_run && s.step == 3'h0) // see R5
    else $error("start with auto enabled did not launch a sequence");
  a_start_self_clear: assert property ((s.st == ST_CONV && conv_done_in && !s.auto_run)
    |=> !s.ctrl[CTRL_START_BIT] && s.st == ST_IDLE) // see R6
    else $error("start bit did not clear after the measurement");
  a_snapshot_pair: assert property (rd_take && rd_idx == IDX_X_HIGH
    |=> s.snap_x == $past(s.x) && s.snap_y == $past(s.y)) // see R11
    else $error("X/Y snapshot not captured on X upper read");
  a_busy_start_drop: assert property ((s.st == ST_CONV && start_try) |=> !conv_start_out) // see R17
    else $error("start write during a measurement restarted it");
  a_seq_length: assert property ((s.st == ST_TOUCH && s.cfg[CFG_TYPE_BIT]) |-> s.step == 3'h0) // see R15
    else $error("X-only sequence ran more than one step");
  a_irq_level: assert property (irq_out == |(s.irq_st & s.irq_mask))
    else $error("interrupt output does not match masked status");
  a_meas_status_set: assert property ((s.st == ST_CONV && conv_done_in) |=> s.irq_st[IRQ_MEAS_BIT])
    else $error("measurement done status not set");

  c_manual_meas: cover property (s.st == ST_CONV && conv_done_in && !s.auto_run);
  c_seq_end: cover property (s.st == ST_TOUCH && s.step == 3'h4);
  c_seq_repeat: cover property (s.st == ST_TOUCH ##1 s.st == ST_CONV && s.step == 3'h0);
  c_snapshot_read: cover property (rd_take && rd_idx == IDX_X_HIGH);

endmodule

//--- sim/tsm_conv_model.sv
/*
  Behavioural converter and panel on the far side of the touch control block.
  Assumes starts come only while idle; each answer encodes route, switches and reference seen at start.
*/
`timescale 1ns/1ps
module tsm_conv_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // From the block, except latency_in which the bench drives
  input wire logic conv_start_in,
  input wire logic [3:0] switch_in,
  input wire logic [1:0] route_in,
  input wire logic ref_in,
  input wire logic [3:0] latency_in,
  // To the block
  output logic conv_done_out,
  output logic [9:0] conv_data_out
);
  logic busy;
  logic [3:0] cnt;
  logic [9:0] held;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      held <= 10'h000;
      conv_done_out <= 1'b0;
      conv_data_out <= 10'h000;
    end else begin
      conv_done_out <= 1'b0;
      // Toggles off the done cycle so a late sample never looks valid
      conv_data_out <= ~conv_data_out;
      if (conv_start_in) begin
        busy <= 1'b1;
        cnt <= latency_in;
        // Route sits in the low bits so low-bit snapshot checks can tell results apart
        held <= {3'h5, ref_in, switch_in, route_in};
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        conv_done_out <= 1'b1;
        conv_data_out <= held;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

//--- sim/testbench.sv
/*
  Self-checking bench for the touch control block: AXI4-Lite master tasks, a table of manual measurements,
  then snapshot, busy-start, interrupt and automatic sequence cases. Assumes the converter model beside it.
*/
`timescale 1ns/1ps
module testbench
  import tsm_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic touch;
    logic [3:0] lat;
    logic is_y;
  } tsm_row_s;
  localparam tsm_row_s ROWS [5] = '{'{8'h41, 1'b0, 4'h2, 1'b0}, '{8'h52, 1'b1, 4'h0, 1'b1},
    '{8'he4, 1'b0, 4'h5, 1'b0}, '{8'hf8, 1'b1, 4'h1, 1'b1}, '{8'h4f, 1'b0, 4'h3, 1'b0}};
  localparam logic [6:0] STEPS [5] = '{{1'b0, ROUTE_YPOS, SW_DRIVE_X}, {1'b0, ROUTE_XPOS, SW_DRIVE_Y},
    {1'b0, ROUTE_XPOS, SW_DRIVE_Z}, {1'b0, ROUTE_YPOS, SW_DRIVE_X}, {1'b0, ROUTE_XPOS, SW_DRIVE_Y}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, touch = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_start, conv_done, ref_sel, irq;
  logic [1:0] bresp, rresp, route, rs;
  logic [31:0] rdata;
  logic [9:0] conv_data;
  logic [3:0] sw;
  logic [3:0] lat = 4'h2;
  logic [9:0] ex = '0, ey = '0, ez = '0;
  logic [7:0] v;
  logic [6:0] c;
  logic [6:0] log [$];
  int starts = 0;
  int n0;
  int num_errors = 0;
  int samples_checked = 0;

  tsm_touch_ctrl dut (.core_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .conv_start_out(conv_start), .conv_done_in(conv_done), .conv_data_in(conv_data),
    .touch_detect_in(touch), .screen_switch_bits_out(sw), .electrode_route_sel_out(route),
    .converter_ref_sel_out(ref_sel), .irq_out(irq));
  tsm_conv_model conv (.core_clk_in(clk), .rstn_in(rstn), .conv_start_in(conv_start), .switch_in(sw),
    .route_in(route), .ref_in(ref_sel), .latency_in(lat), .conv_done_out(conv_done), .conv_data_out(conv_data));

  initial begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      starts = starts + 1;
      log.push_back({ref_sel, route, sw});
    end
  end

  function automatic logic [9:0] fv(input logic [6:0] p);
    return {3'h5, p[6], p[3:0], p[5:4]};
  endfunction

  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s response expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 100) begin
      num_errors++;
      report_and_stop();
    end
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 100) begin
      num_errors++;
      report_and_stop();
    end
    rready <= 1'b0;
    d = rdata[7:0];
    r = rresp;
  endtask

  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk_resp(nm, RESP_OKAY, r);
    chk(nm, {2'b00, exp}, {2'b00, d});
  endtask

  // Polls the start bit; bounded so a stuck operation ends the run
  task automatic wait_idle();
    int n;
    logic [7:0] d;
    logic [1:0] r;
    for (n = 0; n < 60; n++) begin
      rd(IDX_CTRL, d, r);
      if (d[CTRL_START_BIT] === 1'b0) break;
    end
    if (n == 60) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  task automatic read_results();
    rdchk(IDX_X_HIGH, ex[9:2], "x high");
    rdchk(IDX_X_HIGH + 10'h1, ey[9:2], "y high");
    rdchk(IDX_X_HIGH + 10'h2, {1'b0, touch, ez[1:0], ey[1:0], ex[1:0]}, "low bits");
    rdchk(IDX_X_HIGH + 10'h3, ez[9:2], "z high");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdchk(IDX_CTRL, CTRL_RESET, "ctrl reset");
    rdchk(IDX_SEQ_CFG, 8'h00, "cfg reset");
    rdchk(IDX_IRQ_MASK, 8'h00, "mask reset");
    rd(10'h3ff, v, rs);
    chk_resp("unmapped read", RESP_SLVERR, rs);
    wr(10'h3ff, 8'hff, rs);
    chk_resp("unmapped write", RESP_SLVERR, rs);
    wr(IDX_IRQ_MASK, 8'h01, rs);
    for (int i = 0; i < 5; i++) begin
      touch <= ROWS[i].touch;
      lat <= ROWS[i].lat;
      n0 = starts;
      wr(IDX_CTRL, ROWS[i].ctrl, rs);
      wait_idle();
      c = {ROWS[i].ctrl[7], ROWS[i].ctrl[5:0]};
      chk("start count", 10'h001, 10'(starts - n0));
      chk("panel drive", {3'b000, c}, {3'b000, log[$]});
      if (ROWS[i].is_y) ey = fv(c);
      else ex = fv(c);
      read_results();
      chk("irq set", 10'h001, {9'h000, irq});
      wr(IDX_IRQ_STATUS, 8'h07, rs);
      rdchk(IDX_IRQ_STATUS, 8'h00, "status clear");
      chk("irq clear", 10'h000, {9'h000, irq});
    end
    // Snapshot holds X and Y across new X and Y measurements; result writes have no effect
    rdchk(IDX_X_HIGH, ex[9:2], "x snap");
    lat <= 4'h1;
    wr(IDX_CTRL, 8'h6b, rs);
    wait_idle();
    wr(IDX_CTRL, 8'h5b, rs);
    wait_idle();
    wr(IDX_X_HIGH, 8'h00, rs);
    chk_resp("result write", RESP_OKAY, rs);
    rdchk(IDX_Y_HIGH, ey[9:2], "y snap");
    rdchk(IDX_LOW_BITS, {1'b0, touch, ez[1:0], ey[1:0], ex[1:0]}, "low snap");
    ex = fv(7'h2b);
    ey = fv(7'h1b);
    read_results();
    // Second start while busy, with the interrupt masked
    wr(IDX_IRQ_STATUS, 8'h07, rs);
    wr(IDX_IRQ_MASK, 8'h00, rs);
    lat <= 4'hf;
    n0 = starts;
    wr(IDX_CTRL, 8'hc4, rs);
    rdchk(IDX_CTRL, 8'hc4, "start held");
    wr(IDX_CTRL, 8'hc4, rs);
    wait_idle();
    chk("busy start", 10'h001, 10'(starts - n0));
    rdchk(IDX_CTRL, 8'h84, "start cleared");
    rdchk(IDX_IRQ_STATUS, 8'h01, "status masked");
    chk("irq masked", 10'h000, {9'h000, irq});
    wr(IDX_IRQ_STATUS, 8'h07, rs);
    // Automatic X-only sequence ignores the switch and route fields
    wr(IDX_SEQ_CFG, 8'h05, rs);
    lat <= 4'h2;
    n0 = starts;
    wr(IDX_CTRL, 8'h7f, rs);
    wait_idle();
    chk("x seq count", {7'h00, SEQ_LEN_X}, 10'(starts - n0));
    chk("x seq drive", {3'b000, STEPS[0]}, {3'b000, log[$]});
    ex = fv(STEPS[0]);
    rdchk(IDX_X_HIGH, ex[9:2], "x seq result");
    rd(IDX_IRQ_STATUS, v, rs);
    chk("seq done", 10'h001, {9'h000, v[IRQ_SEQ_BIT]});
    // Full X Y Z X Y sequence
    wr(IDX_SEQ_CFG, 8'h01, rs);
    n0 = starts;
    wr(IDX_CTRL, 8'h40, rs);
    wait_idle();
    chk("xyz seq count", {7'h00, SEQ_LEN_XYZ}, 10'(starts - n0));
    for (int k = 0; k < 5; k++) chk("xyz step", {3'b000, STEPS[k]}, {3'b000, log[n0 + k]});
    ex = fv(STEPS[3]);
    ey = fv(STEPS[4]);
    ez = fv(STEPS[2]);
    read_results();
    // Touch starts and repeats sequences until it is released
    wr(IDX_SEQ_CFG, 8'h07, rs);
    n0 = starts;
    touch <= 1'b1;
    repeat (60) @(posedge clk);
    chk("repeat", 10'h001, 10'((starts - n0) > 2));
    rd(IDX_IRQ_STATUS, v, rs);
    chk("touch event", 10'h001, {9'h000, v[IRQ_TOUCH_BIT]});
    touch <= 1'b0;
    repeat (20) @(posedge clk);
    n0 = starts;
    repeat (40) @(posedge clk);
    chk("repeat stop", 10'h000, 10'(starts - n0));
    report_and_stop();
  end
endmodule
